// *** core/srm_level_track.sv ***
// Level tracker: holds the rail status and flags each change of it outside single-supply mode.
// Assumes the detector level is already synchronous to clk_sys.
`timescale 1ns/1ps
module srm_level_track (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic detector_ok,
    input wire logic single_supply,
    output logic level_r,
    output logic change_pulse
);
    import srm_pkg::*;
    logic level_nxt;

    // Single-supply mode pins the level high
    assign level_nxt = single_supply | detector_ok;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            level_r <= RST_LEVEL_STATUS[BIT_SUPPLY];
        end else begin
            level_r <= level_nxt;
        end
    end

    // Both directions count as a change
    assign change_pulse = (level_nxt != level_r) & ~single_supply;
endmodule

// *** core/srm_pkg.sv ***
// Package for the second I/O supply monitor register bank.
// Assumes an APB master with 32-bit data and word-aligned registers.
package srm_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // Printed offsets are register indices; byte address is index times four
    localparam logic [1:0] IDX_IRQ_ENABLE = 2'h0;
    localparam logic [1:0] IDX_IRQ_FLAGS = 2'h1;
    localparam logic [1:0] IDX_LEVEL_STATUS = 2'h2;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAGS = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_LEVEL_STATUS = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h00C;
    localparam int BIT_SUPPLY = 0;
    localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
    localparam logic [7:0] RST_LEVEL_STATUS = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK = 8'h01;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } srm_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } srm_apb_rsp_t;

    typedef enum logic [1:0] {
        SRM_LVL_LOW = 2'b00,
        SRM_LVL_OK = 2'b01
    } srm_level_t;
endpackage

// *** core/srm_regs.sv ***
// Register bank for the second I/O supply monitor, APB slave.
// Assumes a synchronous detector level and a static configuration fuse.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module srm_regs #(
    parameter int PIN_W = 8
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input srm_pkg::srm_apb_req_t apb_req,
    output srm_pkg::srm_apb_rsp_t apb_rsp,
    input wire logic detector_ok,
    input wire logic rail_config_fuse,
    input wire logic [PIN_W-1:0] port_out,
    input wire logic [PIN_W-1:0] port_oe,
    output logic [PIN_W-1:0] pin_out_r,
    output logic [PIN_W-1:0] pin_oe_r,
    output logic rail_ok_event,
    output logic supply_irq
);
    import srm_pkg::*;

    logic second_rail_ok;
    logic change_pulse;
    logic supply_change_irq_en_r;
    logic supply_change_flag_r;
    logic irq_mask_r;
    logic setup_fire;
    logic access_end;
    logic wr_en;
    logic rd_en;
    logic rd_flags;
    logic clr_flag;
    logic [DATA_W-1:0] rdata_nxt;
    logic slverr_nxt;
    logic single_supply;
    logic pready_r;
    logic pslverr_r;
    logic [DATA_W-1:0] prdata_r;

    // Fuse value 1 selects single-supply mode
    assign single_supply = rail_config_fuse;

    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        addr_known = (a == ADDR_IRQ_ENABLE) || (a == ADDR_IRQ_FLAGS) ||
            (a == ADDR_LEVEL_STATUS) || (a == ADDR_IRQ_MASK);
    endfunction

    function automatic logic [DATA_W-1:0] bit0_word(input logic b);
        bit0_word = DATA_ZERO;
        bit0_word[BIT_SUPPLY] = b;
    endfunction

    srm_level_track u_track (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .detector_ok(detector_ok),
        .single_supply(single_supply),
        .level_r(second_rail_ok),
        .change_pulse(change_pulse)
    );

    // One wait state: pready rises in the second access cycle
    assign setup_fire = apb_req.psel & apb_req.penable & ~pready_r;
    assign access_end = apb_req.psel & apb_req.penable & pready_r;
    assign wr_en = access_end & apb_req.pwrite & ~pslverr_r;
    assign rd_en = access_end & ~apb_req.pwrite & ~pslverr_r;
    assign rd_flags = rd_en & (apb_req.paddr == ADDR_IRQ_FLAGS);
    assign clr_flag = wr_en & (apb_req.paddr == ADDR_IRQ_FLAGS) &
        apb_req.pwdata[BIT_SUPPLY];

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= setup_fire;
        end
    end

    always_comb begin
        slverr_nxt = ~addr_known(apb_req.paddr);
        rdata_nxt = DATA_ZERO;
        unique case (apb_req.paddr)
            ADDR_IRQ_ENABLE: begin
                rdata_nxt = bit0_word(supply_change_irq_en_r);
            end
            ADDR_IRQ_FLAGS: begin
                rdata_nxt = bit0_word(supply_change_flag_r &
                    ~single_supply);
            end
            ADDR_LEVEL_STATUS: begin
                rdata_nxt = bit0_word(second_rail_ok);
            end
            ADDR_IRQ_MASK: begin
                rdata_nxt = bit0_word(irq_mask_r);
            end
            default: begin
                rdata_nxt = DATA_ZERO;
            end
        endcase
    end

    // Read data and error prepared during the wait state
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prdata_r <= DATA_ZERO;
            pslverr_r <= 1'b0;
        end else if (setup_fire) begin
            prdata_r <= apb_req.pwrite ? DATA_ZERO : rdata_nxt;
            pslverr_r <= slverr_nxt;
        end else if (access_end) begin
            prdata_r <= DATA_ZERO;
            pslverr_r <= 1'b0;
        end
    end

    assign apb_rsp.pready = pready_r;
    assign apb_rsp.pslverr = pslverr_r;
    assign apb_rsp.prdata = prdata_r;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            supply_change_irq_en_r <= RST_IRQ_ENABLE[BIT_SUPPLY];
        end else if (wr_en && apb_req.paddr == ADDR_IRQ_ENABLE) begin
            supply_change_irq_en_r <= apb_req.pwdata[BIT_SUPPLY];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask_r <= RST_IRQ_MASK[BIT_SUPPLY];
        end else if (wr_en && apb_req.paddr == ADDR_IRQ_MASK) begin
            irq_mask_r <= apb_req.pwdata[BIT_SUPPLY];
        end
    end

    // Set beats both the write-one clear and the read clear
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            supply_change_flag_r <= RST_IRQ_FLAGS[BIT_SUPPLY];
        end else if (change_pulse) begin
            supply_change_flag_r <= 1'b1;
        end else if (single_supply) begin
            supply_change_flag_r <= 1'b0;
        end else if (clr_flag || rd_flags) begin
            supply_change_flag_r <= 1'b0;
        end
    end

    // Held while flag, enable and mask stay set and the fuse is 0, regardless of how long
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            supply_irq <= 1'b0;
        end else begin
            supply_irq <= supply_change_irq_en_r & irq_mask_r &
                supply_change_flag_r & ~single_supply;
        end
    end

    // Twin of the status flop, same reset and next value, so the event
    // equals the status bit in every cycle without a combinational path
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rail_ok_event <= RST_LEVEL_STATUS[BIT_SUPPLY];
        end else begin
            rail_ok_event <= single_supply | detector_ok;
        end
    end

    // Rail pins follow port settings only while the rail is good
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin_out_r <= '0;
            pin_oe_r <= '0;
        end else if (second_rail_ok) begin
            pin_out_r <= port_out;
            pin_oe_r <= port_oe;
        end else begin
            pin_out_r <= '0;
            pin_oe_r <= '0;
        end
    end
endmodule

// *** sim/srm_regs_chk.sv ***
// Checker for the supply monitor register bank.
// Assumes it is bound to srm_regs and sees only its ports.
`timescale 1ns/1ps
module srm_regs_chk #(
    parameter int PIN_W = 8
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input srm_pkg::srm_apb_req_t apb_req,
    input srm_pkg::srm_apb_rsp_t apb_rsp,
    input wire logic detector_ok,
    input wire logic rail_config_fuse,
    input wire logic [PIN_W-1:0] port_out,
    input wire logic [PIN_W-1:0] port_oe,
    input wire logic [PIN_W-1:0] pin_out_r,
    input wire logic [PIN_W-1:0] pin_oe_r,
    input wire logic rail_ok_event,
    input wire logic supply_irq
);
    import srm_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic dual;
    logic clr;
    assign dual = !rail_config_fuse;
    assign clr = apb_rsp.pready && apb_req.pwrite
        && apb_req.paddr == ADDR_IRQ_FLAGS && apb_req.pwdata[0];
    a_pins_hiz: assert property (
        (dual && !detector_ok)[*3] |=> pin_oe_r == '0 && pin_out_r == '0)
        else $error("rail pins driven while rail low");
    a_pins_follow: assert property (
        (dual && detector_ok && $stable(port_oe) && $stable(port_out))[*3]
        |=> pin_oe_r == $past(port_oe) && pin_out_r == $past(port_out))
        else $error("rail pins do not follow port settings");
    a_event_level: assert property (
        (dual && $stable(detector_ok))[*3]
        |=> rail_ok_event == $past(detector_ok))
        else $error("level event differs from rail status");
    a_single_supply: assert property (
        rail_config_fuse[*3] |=> rail_ok_event && !supply_irq)
        else $error("single supply status or request wrong");
    a_clear_irq: assert property (
        clr && $stable(detector_ok) |-> ##2 !supply_irq)
        else $error("request stays after flag clear");
    a_upper_zero: assert property (
        apb_rsp.pready |-> apb_rsp.prdata[31:1] == '0)
        else $error("upper read bits not zero");
    a_apb_wait: assert property (
        apb_req.psel && !apb_req.penable |=> !apb_rsp.pready ##1 apb_rsp.pready)
        else $error("ready not after one wait state");
    a_ready_pulse: assert property (
        apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready longer than one cycle");
    c_irq: cover property ($rose(supply_irq));
    c_err: cover property (apb_rsp.pready && apb_rsp.pslverr);
    c_fuse: cover property (rail_config_fuse && rail_ok_event && !detector_ok);
endmodule

// *** sim/srm_regs_tb.sv ***
// Testbench for the supply monitor register bank.
// Assumes srm_regs answers APB with one wait state.
`timescale 1ns/1ps
module srm_regs_tb;
    import srm_pkg::*;
    logic clk_sys, arst_n, det, fuse, ev, irq, err, en, flag_exp, prev;
    logic [7:0] po, poe, pin_o, pin_e;
    logic [31:0] q;
    srm_apb_req_t req;
    srm_apb_rsp_t rsp;
    int fail_count, check_count, seed;
    srm_regs #(.PIN_W(8)) uut (.clk_sys(clk_sys), .arst_n(arst_n),
        .apb_req(req), .apb_rsp(rsp), .detector_ok(det),
        .rail_config_fuse(fuse), .port_out(po), .port_oe(poe),
        .pin_out_r(pin_o), .pin_oe_r(pin_e), .rail_ok_event(ev),
        .supply_irq(irq));
    initial begin
        clk_sys = 1'h0;
        forever #25 clk_sys = ~clk_sys;
    end
    function automatic logic [7:0] pins_exp(logic ok, logic [7:0] v);
        return ok ? v : 8'h00;
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Pready seen at the falling edge is sampled at the next rising one
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        req <= '{1'h1, 1'h0, w, a, d};
        @(posedge clk_sys);
        req.penable <= 1'h1;
        do begin
            @(negedge clk_sys);
            n++;
        end while (rsp.pready !== 1'h1 && n < 20);
        if (rsp.pready !== 1'h1) begin
            fail_count++;
            print_verdict();
        end
        q = rsp.prdata;
        err = rsp.pslverr;
        @(posedge clk_sys);
        req <= '0;
    endtask
    initial begin
        seed = 32'h8763;
        {arst_n, det, fuse, po, poe} = '0;
        req = '0;
        fail_count = 0;
        check_count = 0;
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'h1;
        apb(1'h0, ADDR_IRQ_ENABLE, 32'h0);
        chk("enable reset", 32'h0, q);
        apb(1'h0, ADDR_IRQ_MASK, 32'h0);
        chk("mask reset", {24'h0, RST_IRQ_MASK}, q);
        apb(1'h1, ADDR_LEVEL_STATUS, 32'hFFFFFFFF);
        apb(1'h0, ADDR_LEVEL_STATUS, 32'h0);
        chk("status ro", 32'h0, q);
        apb(1'h0, 12'h010, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        apb(1'h1, ADDR_IRQ_ENABLE, 32'hFFFFFFFF);
        apb(1'h0, ADDR_IRQ_ENABLE, 32'h0);
        chk("enable bits", 32'h1, q);
        {en, prev, flag_exp} = 3'h4;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys);
            det <= 1'($random(seed));
            po <= 8'($random(seed));
            poe <= 8'($random(seed));
            repeat (4) @(negedge clk_sys);
            flag_exp = flag_exp | (det != prev);
            prev = det;
            chk("pin out", pins_exp(det, po), pin_o);
            chk("pin oe", pins_exp(det, poe), pin_e);
            chk("event", det, ev);
            chk("irq", en & flag_exp, irq);
            apb(1'h1, ADDR_IRQ_FLAGS, 32'h0);
            repeat (2) @(negedge clk_sys);
            chk("irq kept", en & flag_exp, irq);
            if (i[0]) begin
                // Reading the flags register also clears the flag
                apb(1'h0, ADDR_IRQ_FLAGS, 32'h0);
                chk("flag", {31'h0, flag_exp}, q);
                flag_exp = 1'h0;
            end
            apb(1'h0, ADDR_LEVEL_STATUS, 32'h0);
            chk("status", det, q);
            apb(1'h1, ADDR_IRQ_FLAGS, 32'h1);
            repeat (2) @(negedge clk_sys);
            flag_exp = 1'h0;
            chk("irq clear", 32'h0, irq);
            en = 1'($random(seed));
            apb(1'h1, ADDR_IRQ_ENABLE, {31'h0, en});
        end
        @(posedge clk_sys);
        det <= 1'h0;
        fuse <= 1'h1;
        repeat (4) @(negedge clk_sys);
        apb(1'h0, ADDR_LEVEL_STATUS, 32'h0);
        chk("fuse status", 32'h1, q);
        chk("fuse event", 32'h1, ev);
        chk("fuse irq", 32'h0, irq);
        print_verdict();
    end
endmodule
bind srm_regs srm_regs_chk #(.PIN_W(PIN_W)) u_chk (.clk_sys(clk_sys),
    .arst_n(arst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .detector_ok(detector_ok), .rail_config_fuse(rail_config_fuse),
    .port_out(port_out), .port_oe(port_oe), .pin_out_r(pin_out_r),
    .pin_oe_r(pin_oe_r), .rail_ok_event(rail_ok_event),
    .supply_irq(supply_irq));
